// File: core/tsl_pd_timer.sv
// Pickup and dropout delay timer counted in processing intervals
`timescale 1ns/100ps
`default_nettype none
module tsl_pd_timer (
	input wire logic pclk,
	input wire logic presetn,
	tsl_tmr_if.tmr   tif
);
	typedef struct packed {
		logic                      out;
		logic [tsl_pkg::DLY_W-1:0] cnt;
	} tsl_tmr_st_t;

	tsl_tmr_st_t st_ff;
	tsl_tmr_st_t nxt_st;
	logic [tsl_pkg::DLY_W-1:0] need;

	always_comb begin
		nxt_st = st_ff;
		need = st_ff.out ? tif.do_delay : tif.pu_delay;
		if (tif.din == st_ff.out) begin
			// Input went back before the delay ran out
			nxt_st.cnt = '0;
		end else if (st_ff.cnt >= need) begin
			nxt_st.out = tif.din;
			nxt_st.cnt = '0;
		end else if (tif.tick) begin
			nxt_st.cnt = st_ff.cnt + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tif.dout = st_ff.out;
endmodule
`default_nettype wire

// File: core/tsl_pkg.sv
// Constants shared by the trip supervision logic
package tsl_pkg;
	// Clock and processing interval timing
	localparam int CLK_PERIOD_NS    = 25;
	localparam int PROC_INTERVAL_NS = 1000;
	localparam int PROC_INTERVAL_CYC =
		(PROC_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = $clog2(PROC_INTERVAL_CYC);
	localparam logic [TICK_W-1:0] TICK_LAST =
		TICK_W'(PROC_INTERVAL_CYC - 1);

	localparam int DLY_W  = 16;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_LD_PU  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LD_DO  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CB_PU  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_CB_DO  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

	// Control register fields
	localparam int CTRL_W           = 5;
	localparam int CTRL_COLD_EN     = 0;
	localparam int CTRL_COLD_SRC    = 1;
	localparam int CTRL_LOCKOUT     = 2;
	localparam int CTRL_PERM_EN     = 3;
	localparam int CTRL_PERM_LOWSET = 4;

	// Status register fields
	localparam int STAT_LD_DELAYED = 0;
	localparam int STAT_CB_CLOSED  = 1;
	localparam int STAT_CB_OPEN    = 2;
	localparam int STAT_AUX        = 3;
	localparam int STAT_PERMISSIVE = 4;
	localparam int STAT_LOCKOUT    = 5;
	localparam int STAT_TRIP_COND  = 6;
	localparam int STAT_TRIP_OUT   = 7;

	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [DLY_W-1:0]  DLY_RST  = 16'h0000;
endpackage

// File: core/tsl_tmr_if.sv
// Connection between the supervisor and a pickup/dropout timer
`timescale 1ns/100ps
`default_nettype none
interface tsl_tmr_if;
	logic                     din;
	logic [tsl_pkg::DLY_W-1:0] pu_delay;
	logic [tsl_pkg::DLY_W-1:0] do_delay;
	logic                     tick;
	logic                     dout;
	modport ctl (output din, pu_delay, do_delay, tick, input dout);
	modport tmr (input din, pu_delay, do_delay, tick, output dout);
endinterface
`default_nettype wire

// File: core/tsl_top.sv
// Trip supervision logic with APB register access
//
// Overview of operation
// - Delayed load bit picks up after pickup delay
// - Delayed load bit drops after dropout delay
// - Timed closed bit picks up after delay
// - Timed closed bit drops after dropout delay
// - Timed open bit is complement of closed
// - Recloser bits both zero only in lockout
// - Load detect kept apart from recloser reset
// - Permissive energized lets ground elements trip
// - Permissive de-energized blocks selected elements
// - Combined permissive: ground OR gated lowset, ANDed
// - Trip contacts close on trip condition
// - Aux contact asserts on close, feeds timer
`timescale 1ns/100ps
`default_nettype none
module tsl_top (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [tsl_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       load_detect_overcurrent,
	input  wire logic                       lowset_phase_instant,
	input  wire logic                       lowset_ground_instant,
	input  wire logic                       ground_time_overcurrent,
	input  wire logic                       recloser_reset_state,
	input  wire logic                       recloser_cycling_state,
	input  wire logic                       shot_select_bit,
	input  wire logic                       breaker_aux_contact,
	input  wire logic                       permissive_input,
	input  wire logic                       other_trip_terms,
	output logic                            load_detect_delayed,
	output logic                            breaker_closed_timed,
	output logic                            breaker_open_timed,
	output logic                            recloser_lockout,
	output logic                            trip_condition,
	output logic                            trip_contact
);
	typedef struct packed {
		logic [tsl_pkg::CTRL_W-1:0] ctrl;
		logic [tsl_pkg::DLY_W-1:0]  ld_pu;
		logic [tsl_pkg::DLY_W-1:0]  ld_do;
		logic [tsl_pkg::DLY_W-1:0]  cb_pu;
		logic [tsl_pkg::DLY_W-1:0]  cb_do;
		logic [31:0]                rdata;
		logic [2:0]                 aux_sync;
		logic [2:0]                 perm_sync;
		logic                       aux_q;
		logic                       perm_q;
		logic [tsl_pkg::TICK_W-1:0] tick_cnt;
		logic                       tick;
		logic                       trip;
		logic                       contact;
	} tsl_top_st_t;

	tsl_top_st_t st_ff;
	tsl_top_st_t nxt_st;

	tsl_tmr_if ld_if ();
	tsl_tmr_if cb_if ();

	logic       wr_en;
	logic       rd_setup;
	logic       hit;
	logic       lockout;
	logic       cold_sup;
	logic       phase_term;
	logic       ground_sel;
	logic       ground_term;
	logic       trip_now;
	logic [7:0] status;

	// Decodes whether a byte address names a register
	function automatic logic addr_hit(
		input logic [tsl_pkg::ADDR_W-1:0] a
	);
		logic r;
		r = 1'b0;
		case (a)
			tsl_pkg::OFS_CTRL,
			tsl_pkg::OFS_LD_PU,
			tsl_pkg::OFS_LD_DO,
			tsl_pkg::OFS_CB_PU,
			tsl_pkg::OFS_CB_DO,
			tsl_pkg::OFS_STATUS: begin
				r = 1'b1;
			end
			default: begin
				r = 1'b0;
			end
		endcase
		return r;
	endfunction

	// Places a delay setting in the low half of a read word
	function automatic logic [31:0] dly_word(
		input logic [tsl_pkg::DLY_W-1:0] d
	);
		return {16'h0000, d};
	endfunction

	// Lets a synchronised level through once stages two and three agree
	function automatic logic sync_level(
		input logic [2:0] s,
		input logic       q
	);
		return (s[1] == s[2]) ? s[2] : q;
	endfunction

	// Load detect feeds only its own timer, never the recloser
	assign ld_if.din      = load_detect_overcurrent;
	assign ld_if.pu_delay = st_ff.ld_pu;
	assign ld_if.do_delay = st_ff.ld_do;
	assign ld_if.tick     = st_ff.tick;

	// Synchronised aux contact drives the breaker timer
	assign cb_if.din      = st_ff.aux_q;
	assign cb_if.pu_delay = st_ff.cb_pu;
	assign cb_if.do_delay = st_ff.cb_do;
	assign cb_if.tick     = st_ff.tick;

	tsl_pd_timer u_ld_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.tif     (ld_if.tmr)
	);

	tsl_pd_timer u_cb_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.tif     (cb_if.tmr)
	);

	// Zero wait states; unmapped offsets answer with an error
	assign hit      = addr_hit(paddr);
	assign wr_en    = psel & penable & pwrite & hit;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~hit;

	// Lockout when neither recloser state bit is set
	assign lockout = ~(recloser_reset_state | recloser_cycling_state);

	always_comb begin
		// Source of cold load supervision
		if (st_ff.ctrl[tsl_pkg::CTRL_COLD_SRC]) begin
			cold_sup = cb_if.dout;
		end else begin
			cold_sup = ld_if.dout;
		end
		if (st_ff.ctrl[tsl_pkg::CTRL_LOCKOUT]) begin
			cold_sup = cold_sup | ~lockout;
		end
		if (st_ff.ctrl[tsl_pkg::CTRL_COLD_EN]) begin
			phase_term = lowset_phase_instant & cold_sup;
		end else begin
			phase_term = lowset_phase_instant;
		end
	end

	always_comb begin
		ground_sel = ground_time_overcurrent;
		if (st_ff.ctrl[tsl_pkg::CTRL_PERM_LOWSET]) begin
			ground_sel = ground_sel
				| (lowset_ground_instant & shot_select_bit);
		end
		if (st_ff.ctrl[tsl_pkg::CTRL_PERM_EN]) begin
			// Dead input blocks regardless of pickup state
			ground_term = ground_sel & st_ff.perm_q;
		end else begin
			ground_term = ground_sel;
		end
		trip_now = phase_term | ground_term;
	end

	// Live status word, captured into read data at setup
	always_comb begin
		status = 8'h00;
		status[tsl_pkg::STAT_LD_DELAYED] = ld_if.dout;
		status[tsl_pkg::STAT_CB_CLOSED]  = cb_if.dout;
		status[tsl_pkg::STAT_CB_OPEN]    = ~cb_if.dout;
		status[tsl_pkg::STAT_AUX]        = st_ff.aux_q;
		status[tsl_pkg::STAT_PERMISSIVE] = st_ff.perm_q;
		status[tsl_pkg::STAT_LOCKOUT]    = lockout;
		status[tsl_pkg::STAT_TRIP_COND]  = st_ff.trip;
		status[tsl_pkg::STAT_TRIP_OUT]   = st_ff.contact;
	end

	always_comb begin
		nxt_st = st_ff;

		// Processing interval strobe
		nxt_st.tick = 1'b0;
		if (st_ff.tick_cnt == tsl_pkg::TICK_LAST) begin
			nxt_st.tick_cnt = '0;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
		end

		// Pin synchronisers; a change counts once stages two and three agree
		nxt_st.aux_sync  = {st_ff.aux_sync[1:0], breaker_aux_contact};
		nxt_st.perm_sync = {st_ff.perm_sync[1:0], permissive_input};
		nxt_st.aux_q     = sync_level(st_ff.aux_sync, st_ff.aux_q);
		nxt_st.perm_q    = sync_level(st_ff.perm_sync, st_ff.perm_q);

		// Trip condition and contact logic
		nxt_st.trip    = trip_now;
		nxt_st.contact = trip_now | other_trip_terms;

		// Register writes
		if (wr_en) begin
			case (paddr)
				tsl_pkg::OFS_CTRL: begin
					nxt_st.ctrl = pwdata[tsl_pkg::CTRL_W-1:0];
				end
				tsl_pkg::OFS_LD_PU: begin
					nxt_st.ld_pu = pwdata[tsl_pkg::DLY_W-1:0];
				end
				tsl_pkg::OFS_LD_DO: begin
					nxt_st.ld_do = pwdata[tsl_pkg::DLY_W-1:0];
				end
				tsl_pkg::OFS_CB_PU: begin
					nxt_st.cb_pu = pwdata[tsl_pkg::DLY_W-1:0];
				end
				tsl_pkg::OFS_CB_DO: begin
					nxt_st.cb_do = pwdata[tsl_pkg::DLY_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Read data is prepared in the setup phase
		if (rd_setup) begin
			case (paddr)
				tsl_pkg::OFS_CTRL: begin
					nxt_st.rdata = {27'h0, st_ff.ctrl};
				end
				tsl_pkg::OFS_LD_PU: begin
					nxt_st.rdata = dly_word(st_ff.ld_pu);
				end
				tsl_pkg::OFS_LD_DO: begin
					nxt_st.rdata = dly_word(st_ff.ld_do);
				end
				tsl_pkg::OFS_CB_PU: begin
					nxt_st.rdata = dly_word(st_ff.cb_pu);
				end
				tsl_pkg::OFS_CB_DO: begin
					nxt_st.rdata = dly_word(st_ff.cb_do);
				end
				tsl_pkg::OFS_STATUS: begin
					nxt_st.rdata = {24'h0, status};
				end
				default: begin
					nxt_st.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff.ctrl      <= tsl_pkg::CTRL_RST;
			st_ff.ld_pu     <= tsl_pkg::DLY_RST;
			st_ff.ld_do     <= tsl_pkg::DLY_RST;
			st_ff.cb_pu     <= tsl_pkg::DLY_RST;
			st_ff.cb_do     <= tsl_pkg::DLY_RST;
			st_ff.rdata     <= 32'h0000_0000;
			st_ff.aux_sync  <= 3'h0;
			st_ff.perm_sync <= 3'h0;
			st_ff.aux_q     <= 1'b0;
			st_ff.perm_q    <= 1'b0;
			st_ff.tick_cnt  <= '0;
			st_ff.tick      <= 1'b0;
			st_ff.trip      <= 1'b0;
			st_ff.contact   <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Timed bits come from timer flops; the open bit is the inverse of the closed bit
	assign prdata               = st_ff.rdata;
	assign load_detect_delayed  = ld_if.dout;
	assign breaker_closed_timed = cb_if.dout;
	assign breaker_open_timed   = ~cb_if.dout;
	assign recloser_lockout     = lockout;
	assign trip_condition       = st_ff.trip;
	assign trip_contact         = st_ff.contact;
endmodule
`default_nettype wire

// File: dv/tb.sv
// Directed testbench for the trip supervision logic
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        load_detect_overcurrent, lowset_phase_instant;
	logic        lowset_ground_instant, ground_time_overcurrent;
	logic        recloser_reset_state, recloser_cycling_state;
	logic        shot_select_bit, breaker_aux_contact, permissive_input;
	logic        other_trip_terms, load_detect_delayed, recloser_lockout;
	logic        breaker_closed_timed, breaker_open_timed, close_cmd;
	logic        trip_condition, trip_contact, perm_cmd;
	int          failures, n_compared, n;
	tsl_top dut (.*);
	tsl_breaker_model u_brk (.*);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input int d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// Counts cycles until the chosen timed bit reaches v
	task automatic wait_for(input logic c, input logic v, input int lo,
			input int hi);
		n = 0;
		while ((c ? breaker_closed_timed : load_detect_delayed) !== v
				&& n < 400) begin
			@(negedge pclk);
			n++;
		end
		chk(32'(n >= lo && n <= hi), 32'h1);
	endtask
	task automatic summarize();
		if (failures == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		#(10000 * 25);
		failures++;
		summarize();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{load_detect_overcurrent, lowset_phase_instant, close_cmd} = '0;
		{lowset_ground_instant, ground_time_overcurrent, perm_cmd} = '0;
		{recloser_reset_state, recloser_cycling_state} = '0;
		{shot_select_bit, other_trip_terms} = '0;
		failures = 0;
		n_compared = 0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, tsl_pkg::OFS_STATUS, 0);
		chk(rd, 32'h24);
		apb(1'b0, 8'h18, 0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, tsl_pkg::OFS_LD_PU, 32'hffff0002);
		apb(1'b0, tsl_pkg::OFS_LD_PU, 0);
		chk(rd, 32'h2);
		apb(1'b1, tsl_pkg::OFS_LD_DO, 3);
		apb(1'b1, tsl_pkg::OFS_CTRL, 5);
		@(posedge pclk);
		lowset_phase_instant <= 1'b1;
		load_detect_overcurrent <= 1'b1;
		repeat (30) @(negedge pclk);
		chk(32'(trip_condition), 32'h0);
		wait_for(1'b0, 1'b1, 13, 52);
		repeat (2) @(negedge pclk);
		chk(32'(trip_condition), 32'h1);
		@(posedge pclk);
		load_detect_overcurrent <= 1'b0;
		repeat (60) @(posedge pclk);
		load_detect_overcurrent <= 1'b1;
		@(posedge pclk);
		load_detect_overcurrent <= 1'b0;
		wait_for(1'b0, 1'b0, 83, 122);
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			{recloser_reset_state, recloser_cycling_state} <= 2'(i);
			repeat (2) @(negedge pclk);
			chk(32'(trip_condition), 32'(i != 0));
		end
		@(posedge pclk);
		{recloser_reset_state, recloser_cycling_state} <= 2'h0;
		lowset_phase_instant <= 1'b0;
		apb(1'b1, tsl_pkg::OFS_CB_PU, 1);
		apb(1'b1, tsl_pkg::OFS_CB_DO, 2);
		apb(1'b1, tsl_pkg::OFS_CTRL, 3);
		@(posedge pclk);
		close_cmd <= 1'b1;
		@(posedge pclk);
		close_cmd <= 1'b0;
		wait_for(1'b1, 1'b1, 7, 46);
		apb(1'b0, tsl_pkg::OFS_STATUS, 0);
		chk(32'(rd[3:1]), 32'h5);
		@(posedge pclk);
		lowset_phase_instant <= 1'b1;
		repeat (2) @(negedge pclk);
		chk(32'(trip_contact), 32'h1);
		@(posedge pclk);
		lowset_phase_instant <= 1'b0;
		repeat (20) @(posedge pclk);
		chk(32'(breaker_aux_contact), 32'h0);
		close_cmd <= 1'b1;
		@(posedge pclk);
		close_cmd <= 1'b0;
		repeat (60) @(negedge pclk);
		chk(32'(breaker_closed_timed), 32'h1);
		@(posedge pclk);
		other_trip_terms <= 1'b1;
		@(posedge pclk);
		other_trip_terms <= 1'b0;
		@(posedge pclk);
		wait_for(1'b1, 1'b0, 47, 86);
		apb(1'b1, tsl_pkg::OFS_CTRL, 32'h18);
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk);
			{shot_select_bit, lowset_ground_instant} <= 2'(i >> 2);
			{ground_time_overcurrent, perm_cmd} <= 2'(i);
			n = i[0] & (i[1] | i[2] & i[3]);
			repeat (7) @(negedge pclk);
			chk(32'(trip_condition), 32'(n));
		end
		apb(1'b1, tsl_pkg::OFS_CTRL, 32'h08);
		ground_time_overcurrent <= 1'b0;
		repeat (2) @(negedge pclk);
		chk(32'(trip_condition), 32'h0);
		summarize();
	end
endmodule
bind tsl_top tsl_props u_props (.*);
`default_nettype wire

// File: dv/tsl_breaker_model.sv
// Breaker and input contact model for the trip supervision bench
`timescale 1ns/100ps
`default_nettype none
module tsl_breaker_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic trip_contact,
	input  wire logic close_cmd,
	input  wire logic perm_cmd,
	output logic      breaker_aux_contact,
	output logic      permissive_input
);
	// Trip coil wins over a close request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			breaker_aux_contact <= 1'b0;
			permissive_input    <= 1'b0;
		end else begin
			permissive_input <= perm_cmd;
			if (trip_contact) begin
				breaker_aux_contact <= 1'b0;
			end else if (close_cmd) begin
				breaker_aux_contact <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: dv/tsl_props.sv
// Port checks of the trip supervision logic
`timescale 1ns/100ps
`default_nettype none
module tsl_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load_detect_overcurrent,
	input wire logic recloser_reset_state,
	input wire logic recloser_cycling_state,
	input wire logic breaker_aux_contact,
	input wire logic other_trip_terms,
	input wire logic load_detect_delayed,
	input wire logic breaker_closed_timed,
	input wire logic breaker_open_timed,
	input wire logic recloser_lockout,
	input wire logic trip_condition,
	input wire logic trip_contact
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_inv; breaker_open_timed == !breaker_closed_timed; endproperty
	a_inv: assert property (p_inv) else $error("open bit wrong");
	property p_lko;
		recloser_lockout == !(recloser_reset_state | recloser_cycling_state);
	endproperty
	a_lko: assert property (p_lko) else $error("lockout wrong");
	property p_ldu;
		$rose(load_detect_delayed) |-> $past(load_detect_overcurrent);
	endproperty
	a_ldu: assert property (p_ldu) else $error("load rise early");
	property p_ldd;
		$fell(load_detect_delayed) |-> !$past(load_detect_overcurrent);
	endproperty
	a_ldd: assert property (p_ldd) else $error("load fall early");
	// Aux pin passes three sync stages before the timer
	property p_cbu;
		$rose(breaker_closed_timed) |-> $past(breaker_aux_contact, 4);
	endproperty
	a_cbu: assert property (p_cbu) else $error("closed rise early");
	property p_cbd;
		$fell(breaker_closed_timed) |-> !$past(breaker_aux_contact, 4);
	endproperty
	a_cbd: assert property (p_cbd) else $error("closed fall early");
	property p_con; trip_condition |-> trip_contact; endproperty
	a_con: assert property (p_con) else $error("contact open");
	property p_oth; other_trip_terms |=> trip_contact; endproperty
	a_oth: assert property (p_oth) else $error("other term lost");
endmodule
`default_nettype wire
